/* src/dpg_defines.svh */
// Address map, field masks and reset values of the display palette.
`ifndef DPG_DEFINES_SVH
`define DPG_DEFINES_SVH

// ----------------------------------------------------------------------
// Register windows (byte addresses)
// ----------------------------------------------------------------------
`define DPG_LEG_BASE_A  20'h4A000
`define DPG_LEG_BASE_B  20'h4A800
`define DPG_PREC_BASE_A 20'h4B000
`define DPG_PREC_BASE_B 20'h4C000
`define DPG_MAX_BASE_A  20'h4D000
`define DPG_MAX_BASE_B  20'h4D010
`define DPG_LEG_SPAN    20'h00400
`define DPG_PREC_SPAN   20'h01000
`define DPG_MAX_SPAN    20'h0000C

// ----------------------------------------------------------------------
// Field masks and reset values
// ----------------------------------------------------------------------
`define DPG_LEG_MASK    32'h00FFFFFF
`define DPG_P10_MASK    32'h3FFFFFFF
`define DPG_EVEN_MASK   32'h3F0FC3F0
`define DPG_MAX_MASK    32'h0001FFFF
`define DPG_MAX_RESET   17'h10000
`define DPG_FULL_BE     4'hF

`endif

/* src/dpg_pkg.sv */
// Types shared by both ends of the display palette link.
package dpg_pkg;

	typedef enum logic [1:0] {
		DPG_MODE_LEGACY = 2'h0,
		DPG_MODE_P10    = 2'h1,
		DPG_MODE_P12    = 2'h2,
		DPG_MODE_RSVD   = 2'h3
	} dpg_mode_type;

	typedef enum logic [1:0] {
		DPG_REG_NONE = 2'h0,
		DPG_REG_LEG  = 2'h1,
		DPG_REG_PREC = 2'h2,
		DPG_REG_MAX  = 2'h3
	} dpg_region_type;

	typedef enum logic [1:0] {
		DPG_HOST_IDLE = 2'h0,
		DPG_HOST_REQ  = 2'h1,
		DPG_HOST_WAIT = 2'h3
	} dpg_host_st_type;

	typedef struct packed {
		logic              s1_valid;
		logic              s1_bypass;
		logic              s1_indexed;
		dpg_mode_type      s1_mode;
		logic [35:0]       s1_pix;
		logic [2:0][16:0]  max_pt;
		logic              rd_valid;
		logic [31:0]       rd_data;
		logic              vga_valid;
		logic [17:0]       vga_data;
		logic              out_valid;
		logic [35:0]       out_data;
	} dpg_dev_state_type;

	typedef struct packed {
		dpg_host_st_type   st;
		logic              req;
		logic              we;
		logic [19:0]       addr;
		logic [31:0]       wdata;
		logic              rsp_valid;
		logic [31:0]       rsp_data;
		logic              vga_we;
		logic              vga_re;
		logic [7:0]        vga_index;
		logic [17:0]       vga_wdata;
		logic              vga_rsp_valid;
		logic [17:0]       vga_rsp_data;
		logic              pix_valid;
		logic              pix_gamma_en;
		logic              pix_indexed;
		logic [35:0]       pix_data;
		dpg_mode_type      mode;
	} dpg_host_state_type;

endpackage : dpg_pkg

/* src/dpg_if.sv */
// Link between the palette and the party that programs it and feeds pixels.
interface dpg_if;
	logic                 reg_req;
	logic                 reg_we;
	logic [19:0]          reg_addr;
	logic [3:0]           reg_be;
	logic [31:0]          reg_wdata;
	logic [31:0]          reg_rdata;
	logic                 reg_rvalid;
	logic                 vga_we;
	logic                 vga_re;
	logic [7:0]           vga_index;
	logic [17:0]          vga_wdata;
	logic [17:0]          vga_rdata;
	logic                 vga_rvalid;
	logic                 pix_valid;
	logic                 pix_gamma_en;
	logic                 pix_indexed;
	logic [35:0]          pix_data;
	dpg_pkg::dpg_mode_type pal_mode;

	modport device (
		input  reg_req, reg_we, reg_addr, reg_be, reg_wdata,
		output reg_rdata, reg_rvalid,
		input  vga_we, vga_re, vga_index, vga_wdata,
		output vga_rdata, vga_rvalid,
		input  pix_valid, pix_gamma_en, pix_indexed, pix_data, pal_mode
	);

	modport host (
		output reg_req, reg_we, reg_addr, reg_be, reg_wdata,
		input  reg_rdata, reg_rvalid,
		output vga_we, vga_re, vga_index, vga_wdata,
		input  vga_rdata, vga_rvalid,
		output pix_valid, pix_gamma_en, pix_indexed, pix_data, pal_mode
	);
endinterface : dpg_if

/* src/dpg_palette.sv */
// Display palette device end: lookup RAMs, register access, pixel remap.
// Overview of operation
// - Legacy table 256 entries, red 23:16, blue 7:0.
// - Indexed pixel picks 24-bit colour, padded 36.
// - Legacy gamma chops to 24, looks up, pads.
// - Precision table 1024 entries, ten bits per colour.
// - Ten-bit gamma chops to 30, looks up, pads.
// - Chop drops component LSBs; pad appends them.
// - Per pixel gamma enable selects palette or bypass.
// - Software touches palette only with clock running.
// - Software writes palette only as full dwords.
// - Ten-bit entry red 29:20, green 19:10, blue 9:0.
// - Odd dword holds base bits 11:2 per colour.
// - Even dword holds base 1:0 and fraction.
// - Twelve-bit points are unsigned 12.4 values.
// - 513 points; last from per-pipe maximum register.
// - Final point is 17 bits, 13.4 format.
// - Interpolate between the two adjacent points.
// - Software samples every eighth value up to 4096.
// - Software curve never decreases between points.
// - Mode 01b reads table as ten-bit entries.
// - Mode 10b reads table as even/odd pairs.
// - Legacy table also via VGA, six-bit components.
`include "dpg_defines.svh"

module dpg_palette #(
	parameter bit PIPE_B = 1'b0
) (
	input  wire logic        core_clk_i,  // Core display clock, 20 MHz.
	input  wire logic        resetn_i,    // Asynchronous reset, active low.
	dpg_if.device            lnk,         // Link to programming/pixel side.
	output logic             out_valid_o, // Remapped pixel valid.
	output logic [35:0]      out_data_o   // Remapped pixel, 12 bits/colour.
);

	localparam logic [19:0] LEG_BASE  =
		PIPE_B ? `DPG_LEG_BASE_B : `DPG_LEG_BASE_A;
	localparam logic [19:0] PREC_BASE =
		PIPE_B ? `DPG_PREC_BASE_B : `DPG_PREC_BASE_A;
	localparam logic [19:0] MAX_BASE  =
		PIPE_B ? `DPG_MAX_BASE_B : `DPG_MAX_BASE_A;

	// ------------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------------
	// Entries have no reset value; software must fill them before use.
	logic [31:0]                  leg_ram  [0:255];
	logic [31:0]                  prec_ram [0:1023];
	dpg_pkg::dpg_dev_state_type   cur;
	dpg_pkg::dpg_dev_state_type   next_cur;
	dpg_pkg::dpg_region_type      wr_region;
	logic                         wr_ok;
	logic [35:0]                  lut_pix;
	logic [31:0]                  prec_mask;

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic dpg_pkg::dpg_region_type region_of(
		input logic [19:0] addr
	);
		if (addr >= LEG_BASE && addr < LEG_BASE + `DPG_LEG_SPAN) begin
			return dpg_pkg::DPG_REG_LEG;
		end else if (addr >= PREC_BASE &&
			addr < PREC_BASE + `DPG_PREC_SPAN) begin
			return dpg_pkg::DPG_REG_PREC;
		end else if (addr >= MAX_BASE && addr < MAX_BASE + `DPG_MAX_SPAN) begin
			return dpg_pkg::DPG_REG_MAX;
		end else begin
			return dpg_pkg::DPG_REG_NONE;
		end
	endfunction : region_of

	// Joins the two halves of a reference point for channel c (2 is red).
	function automatic logic [15:0] ref_point(
		input logic [31:0] even_w,
		input logic [31:0] odd_w,
		input int          c
	);
		return {odd_w[10*c +: 10], even_w[10*c+8 +: 2],
			even_w[10*c+4 +: 4]};
	endfunction : ref_point

	// A falling step would wrap the difference, so it is held flat instead.
	function automatic logic [11:0] interp(
		input logic [15:0] p0,
		input logic [16:0] p1,
		input logic [2:0]  frac
	);
		logic [16:0] diff;
		logic [20:0] acc;
		diff = (p1 > {1'b0, p0}) ? p1 - {1'b0, p0} : 17'h00000;
		acc  = {2'h0, p0, 3'h0} + ({4'h0, diff} * {18'h00000, frac});
		if (acc[20:19] != 2'h0) begin
			return 12'hFFF;
		end else begin
			return acc[18:7];
		end
	endfunction : interp

	// ------------------------------------------------------------------
	// Lookup of the pixel held in the first stage
	// ------------------------------------------------------------------
	always_comb begin
		logic [11:0] comp;
		logic [31:0] e;
		logic [8:0]  pt;
		logic [9:0]  d0;
		logic [15:0] p0;
		logic [16:0] p1;
		comp    = 12'h000;
		e       = 32'h00000000;
		pt      = 9'h000;
		d0      = 10'h000;
		p0      = 16'h0000;
		p1      = 17'h00000;
		lut_pix = 36'h000000000;
		for (int c = 0; c < 3; c++) begin
			comp = cur.s1_pix[12*c +: 12];
			pt   = comp[11:3];
			d0   = {pt, 1'b0};
			e    = 32'h00000000;
			p0   = 16'h0000;
			p1   = 17'h00000;
			if (cur.s1_indexed) begin
				e = leg_ram[cur.s1_pix[7:0]];
				lut_pix[12*c +: 12] = {e[8*c +: 8], 4'h0};
			end else begin
				case (cur.s1_mode)
					dpg_pkg::DPG_MODE_P10: begin
						e = prec_ram[comp[11:2]];
						lut_pix[12*c +: 12] = {e[10*c +: 10], 2'h0};
					end
					dpg_pkg::DPG_MODE_P12: begin
						p0 = ref_point(prec_ram[d0], prec_ram[d0 + 10'h001], c);
						if (pt == 9'h1FF) begin
							p1 = cur.max_pt[2 - c];
						end else begin
							p1 = {1'b0, ref_point(prec_ram[d0 + 10'h002],
								prec_ram[d0 + 10'h003], c)};
						end
						lut_pix[12*c +: 12] = interp(p0, p1, comp[2:0]);
					end
					default: begin
						e = leg_ram[comp[11:4]];
						lut_pix[12*c +: 12] = {e[8*c +: 8], 4'h0};
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------------
	// Register access and pipeline
	// ------------------------------------------------------------------
	assign wr_region = region_of(lnk.reg_addr);
	// Partial writes are dropped whole rather than merged into an entry.
	assign wr_ok = lnk.reg_req && lnk.reg_we &&
		(lnk.reg_be == `DPG_FULL_BE);
	assign prec_mask = (lnk.pal_mode == dpg_pkg::DPG_MODE_P12 &&
		!lnk.reg_addr[2]) ? `DPG_EVEN_MASK : `DPG_P10_MASK;

	always_comb begin
		logic [1:0] k;
		k = lnk.reg_addr[3:2];
		next_cur = cur;
		next_cur.s1_valid   = lnk.pix_valid;
		next_cur.s1_pix     = lnk.pix_data;
		next_cur.s1_indexed = lnk.pix_indexed;
		next_cur.s1_mode    = lnk.pal_mode;
		next_cur.s1_bypass  = !lnk.pix_gamma_en && !lnk.pix_indexed;
		next_cur.rd_valid   = lnk.reg_req && !lnk.reg_we;
		case (wr_region)
			dpg_pkg::DPG_REG_LEG:
				next_cur.rd_data = leg_ram[lnk.reg_addr[9:2]];
			dpg_pkg::DPG_REG_PREC:
				next_cur.rd_data = prec_ram[lnk.reg_addr[11:2]];
			dpg_pkg::DPG_REG_MAX:
				next_cur.rd_data = {15'h0000, cur.max_pt[k]};
			default:
				next_cur.rd_data = 32'h00000000;
		endcase
		if (wr_ok && wr_region == dpg_pkg::DPG_REG_MAX) begin
			next_cur.max_pt[k] = lnk.reg_wdata[16:0];
		end
		next_cur.vga_valid = lnk.vga_re;
		next_cur.vga_data  = {leg_ram[lnk.vga_index][23:18],
			leg_ram[lnk.vga_index][15:10],
			leg_ram[lnk.vga_index][7:2]};
		next_cur.out_valid = cur.s1_valid;
		next_cur.out_data  = cur.s1_bypass ? cur.s1_pix : lut_pix;
	end

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cur <= '0;
			cur.max_pt <= {3{`DPG_MAX_RESET}};
		end else begin
			cur <= next_cur;
		end
	end

	// VGA writes land after memory-mapped ones, so VGA wins a collision.
	always_ff @(posedge core_clk_i) begin
		if (wr_ok && wr_region == dpg_pkg::DPG_REG_LEG) begin
			leg_ram[lnk.reg_addr[9:2]] <= lnk.reg_wdata & `DPG_LEG_MASK;
		end
		if (wr_ok && wr_region == dpg_pkg::DPG_REG_PREC) begin
			prec_ram[lnk.reg_addr[11:2]] <= lnk.reg_wdata & prec_mask;
		end
		if (lnk.vga_we) begin
			leg_ram[lnk.vga_index] <= {8'h00,
				lnk.vga_wdata[17:12], 2'h0,
				lnk.vga_wdata[11:6], 2'h0,
				lnk.vga_wdata[5:0], 2'h0};
		end
	end

	assign lnk.reg_rdata  = cur.rd_data;
	assign lnk.reg_rvalid = cur.rd_valid;
	assign lnk.vga_rdata  = cur.vga_data;
	assign lnk.vga_rvalid = cur.vga_valid;
	assign out_valid_o    = cur.out_valid;
	assign out_data_o     = cur.out_data;

endmodule : dpg_palette

/* src/dpg_host.sv */
// Programming and pixel-feeding end of the display palette link.
`include "dpg_defines.svh"

module dpg_host (
	input  wire logic        core_clk_i,      // Core display clock, 20 MHz.
	input  wire logic        resetn_i,        // Asynchronous reset, low.
	dpg_if.host              lnk,             // Link to the palette.
	input  wire logic        disp_clk_on_i,   // Display clock is running.
	input  wire logic        cmd_valid_i,     // Register command offered.
	input  wire logic        cmd_write_i,     // Command is a write.
	input  wire logic [19:0] cmd_addr_i,      // Byte address of dword.
	input  wire logic [31:0] cmd_wdata_i,     // Write data.
	output logic             cmd_ready_o,     // Command taken this cycle.
	output logic             rsp_valid_o,     // Read data valid pulse.
	output logic [31:0]      rsp_data_o,      // Read data.
	input  wire logic        vga_we_i,        // VGA palette write.
	input  wire logic        vga_re_i,        // VGA palette read.
	input  wire logic [7:0]  vga_index_i,     // VGA palette index.
	input  wire logic [17:0] vga_wdata_i,     // Six bits per colour.
	output logic             vga_rsp_valid_o, // VGA read data valid.
	output logic [17:0]      vga_rsp_data_o,  // VGA read data.
	input  wire logic        pix_valid_i,     // Blended pixel valid.
	input  wire logic        pix_gamma_en_i,  // Source plane gamma enable.
	input  wire logic        pix_indexed_i,   // Pixel is an 8-bit index.
	input  wire logic [35:0] pix_data_i,      // Blended pixel.
	input  wire logic [1:0]  pal_mode_i       // Pipe palette mode field.
);

	dpg_pkg::dpg_host_state_type cur;
	dpg_pkg::dpg_host_state_type next_cur;

	// ------------------------------------------------------------------
	// Command sequencing
	// ------------------------------------------------------------------
	// Register commands are held off, and VGA accesses dropped, while the display clock is stopped.
	assign cmd_ready_o = (cur.st == dpg_pkg::DPG_HOST_IDLE) &&
		disp_clk_on_i;

	always_comb begin
		next_cur = cur;
		next_cur.req = 1'b0;
		next_cur.rsp_valid = 1'b0;
		case (cur.st)
			dpg_pkg::DPG_HOST_IDLE: begin
				if (cmd_valid_i && cmd_ready_o) begin
					next_cur.st    = dpg_pkg::DPG_HOST_REQ;
					next_cur.req   = 1'b1;
					next_cur.we    = cmd_write_i;
					next_cur.addr  = cmd_addr_i;
					next_cur.wdata = cmd_wdata_i;
				end
			end
			dpg_pkg::DPG_HOST_REQ: begin
				next_cur.st = cur.we ? dpg_pkg::DPG_HOST_IDLE :
					dpg_pkg::DPG_HOST_WAIT;
			end
			dpg_pkg::DPG_HOST_WAIT: begin
				if (lnk.reg_rvalid) begin
					next_cur.st        = dpg_pkg::DPG_HOST_IDLE;
					next_cur.rsp_valid = 1'b1;
					next_cur.rsp_data  = lnk.reg_rdata;
				end
			end
			default: begin
				next_cur.st = dpg_pkg::DPG_HOST_IDLE;
			end
		endcase
		next_cur.vga_we        = vga_we_i && disp_clk_on_i;
		next_cur.vga_re        = vga_re_i && disp_clk_on_i;
		next_cur.vga_index     = vga_index_i;
		next_cur.vga_wdata     = vga_wdata_i;
		next_cur.vga_rsp_valid = lnk.vga_rvalid;
		next_cur.vga_rsp_data  = lnk.vga_rvalid ? lnk.vga_rdata :
			cur.vga_rsp_data;
		next_cur.pix_valid     = pix_valid_i;
		next_cur.pix_gamma_en  = pix_gamma_en_i;
		next_cur.pix_indexed   = pix_indexed_i;
		next_cur.pix_data      = pix_data_i;
		next_cur.mode          = dpg_pkg::dpg_mode_type'(pal_mode_i);
	end

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign lnk.reg_req      = cur.req;
	assign lnk.reg_we       = cur.we;
	assign lnk.reg_addr     = cur.addr;
	assign lnk.reg_be       = `DPG_FULL_BE;
	assign lnk.reg_wdata    = cur.wdata;
	assign lnk.vga_we       = cur.vga_we;
	assign lnk.vga_re       = cur.vga_re;
	assign lnk.vga_index    = cur.vga_index;
	assign lnk.vga_wdata    = cur.vga_wdata;
	assign lnk.pix_valid    = cur.pix_valid;
	assign lnk.pix_gamma_en = cur.pix_gamma_en;
	assign lnk.pix_indexed  = cur.pix_indexed;
	assign lnk.pix_data     = cur.pix_data;
	assign lnk.pal_mode     = cur.mode;
	assign rsp_valid_o      = cur.rsp_valid;
	assign rsp_data_o       = cur.rsp_data;
	assign vga_rsp_valid_o  = cur.vga_rsp_valid;
	assign vga_rsp_data_o   = cur.vga_rsp_data;

endmodule : dpg_host

/* verif/dpg_monitor.sv */
// Concurrent checks on the palette link and the remapped pixel output.
`include "dpg_defines.svh"

module dpg_monitor #(
	parameter bit PIPE_B = 1'b0
) (
	input wire logic                  core_clk_i,   // Clock.
	input wire logic                  resetn_i,     // Reset, low.
	input wire logic                  reg_req,      // Register request.
	input wire logic                  reg_we,       // Request writes.
	input wire logic [19:0]           reg_addr,     // Byte address.
	input wire logic [31:0]           reg_wdata,    // Write data.
	input wire logic [31:0]           reg_rdata,    // Read data.
	input wire logic                  reg_rvalid,   // Read answer.
	input wire logic                  vga_we,       // VGA write.
	input wire logic                  vga_re,       // VGA read.
	input wire logic [7:0]            vga_index,    // VGA entry.
	input wire logic [17:0]           vga_wdata,    // VGA write data.
	input wire logic [17:0]           vga_rdata,    // VGA read data.
	input wire logic                  vga_rvalid,   // VGA answer.
	input wire logic                  pix_valid,    // Pixel in.
	input wire logic                  pix_gamma_en, // Plane gamma.
	input wire logic                  pix_indexed,  // Index pixel.
	input wire logic [35:0]           pix_data,     // Pixel value.
	input wire dpg_pkg::dpg_mode_type pal_mode,     // Palette mode.
	input wire logic                  out_valid_o,  // Pixel out.
	input wire logic [35:0]           out_data_o    // Remapped pixel.
);
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------
	localparam logic [19:0] LEG = PIPE_B ? `DPG_LEG_BASE_B : `DPG_LEG_BASE_A;
	localparam logic [19:0] PRC = PIPE_B ? `DPG_PREC_BASE_B : `DPG_PREC_BASE_A;
	logic leg_hit;
	logic prec_hit;
	assign leg_hit = reg_addr >= LEG && reg_addr < LEG + `DPG_LEG_SPAN;
	assign prec_hit = reg_addr >= PRC && reg_addr < PRC + `DPG_PREC_SPAN;

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!resetn_i);

	// ------------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------------
	a_read_answered: assert property (
		reg_req && !reg_we |=> reg_rvalid) else $error("read unanswered");
	a_answer_has_cause: assert property (
		reg_rvalid |-> $past(reg_req) && !$past(reg_we))
		else $error("stray read answer");
	a_legacy_top_zero: assert property (
		reg_req && !reg_we && leg_hit |=> reg_rdata[31:24] == 8'h00)
		else $error("legacy reserved byte not zero");
	a_prec_top_zero: assert property (
		reg_req && !reg_we && prec_hit |=> reg_rdata[31:30] == 2'h0)
		else $error("precision reserved bits not zero");
	a_legacy_write_back: assert property (
		reg_req && reg_we && leg_hit ##2 reg_req && !reg_we &&
		reg_addr == $past(reg_addr, 2)
		|=> reg_rdata == ($past(reg_wdata, 3) & `DPG_LEG_MASK))
		else $error("legacy entry read back wrong");
	a_vga_answered: assert property (
		vga_re |=> vga_rvalid) else $error("VGA read unanswered");
	a_vga_write_back: assert property (
		vga_we ##1 vga_re && !vga_we && vga_index == $past(vga_index)
		|=> vga_rdata == $past(vga_wdata, 2))
		else $error("VGA entry read back wrong");
	a_bypass_exact: assert property (
		pix_valid && !pix_gamma_en && !pix_indexed
		|-> ##2 out_valid_o && out_data_o == $past(pix_data, 2))
		else $error("bypassed pixel altered");
	a_idle_no_pixel: assert property (
		!pix_valid |-> ##2 !out_valid_o) else $error("pixel from nothing");
	a_ten_bit_pad: assert property (
		pix_valid && pix_gamma_en && !pix_indexed &&
		pal_mode == dpg_pkg::DPG_MODE_P10 |-> ##2 out_valid_o &&
		out_data_o[1:0] == 2'h0 && out_data_o[13:12] == 2'h0 &&
		out_data_o[25:24] == 2'h0) else $error("ten-bit pad not zero");
	a_legacy_pad: assert property (
		pix_valid && (pix_indexed || pix_gamma_en && pal_mode[1] == pal_mode[0])
		|-> ##2 out_valid_o && out_data_o[3:0] == 4'h0 &&
		out_data_o[15:12] == 4'h0 && out_data_o[27:24] == 4'h0)
		else $error("legacy pad not zero");
endmodule : dpg_monitor

/* verif/display_palette_gamma_lut_test.sv */
// Self-checking bench: host end and palette end joined over the link.
`include "dpg_defines.svh"

module display_palette_gamma_lut_test;
	timeunit 1ns;
	timeprecision 1ps;

	logic        core_clk_i, resetn_i, disp_clk_on_i, cmd_valid_i, g, ix;
	logic        cmd_write_i, vga_we_i, vga_re_i, pix_valid_i, pix_indexed_i;
	logic        pix_gamma_en_i, cmd_ready_o, rsp_valid_o, vga_rsp_valid_o;
	logic        out_valid_o;
	logic [19:0] cmd_addr_i;
	logic [31:0] cmd_wdata_i, rsp_data_o, d;
	logic [7:0]  vga_index_i, vi;
	logic [17:0] vga_wdata_i, vga_rsp_data_o, vd;
	logic [35:0] pix_data_i, out_data_o, pd;
	logic [1:0]  pal_mode_i, m;
	logic [31:0] leg [256];
	logic [31:0] prec [1024];
	logic [16:0] fin [3];
	logic [35:0] q_pix [$];
	logic [31:0] q_rsp [$];
	logic [17:0] q_vga [$];
	int          n_fail, samples_checked, cycles;

	dpg_if lnk ();
	dpg_host dpg_host_i (
		.core_clk_i, .resetn_i, .lnk(lnk), .disp_clk_on_i, .cmd_valid_i,
		.cmd_write_i, .cmd_addr_i, .cmd_wdata_i, .cmd_ready_o, .rsp_valid_o,
		.rsp_data_o, .vga_we_i, .vga_re_i, .vga_index_i, .vga_wdata_i,
		.vga_rsp_valid_o, .vga_rsp_data_o, .pix_valid_i, .pix_gamma_en_i,
		.pix_indexed_i, .pix_data_i, .pal_mode_i
	);
	dpg_palette #(.PIPE_B(1'b0)) dpg_palette_i (
		.core_clk_i, .resetn_i, .lnk(lnk), .out_valid_o, .out_data_o
	);
	dpg_monitor #(.PIPE_B(1'b0)) dpg_monitor_i (
		.core_clk_i, .resetn_i, .out_valid_o, .out_data_o,
		.reg_req(lnk.reg_req), .reg_we(lnk.reg_we), .reg_addr(lnk.reg_addr),
		.reg_wdata(lnk.reg_wdata), .reg_rdata(lnk.reg_rdata),
		.reg_rvalid(lnk.reg_rvalid), .vga_we(lnk.vga_we), .vga_re(lnk.vga_re),
		.vga_index(lnk.vga_index), .vga_wdata(lnk.vga_wdata),
		.vga_rdata(lnk.vga_rdata), .vga_rvalid(lnk.vga_rvalid),
		.pix_valid(lnk.pix_valid), .pix_gamma_en(lnk.pix_gamma_en),
		.pix_indexed(lnk.pix_indexed), .pix_data(lnk.pix_data),
		.pal_mode(lnk.pal_mode)
	);

	// ------------------------------------------------------------------
	// Reference model and drivers
	// ------------------------------------------------------------------
	function automatic logic [17:0] six(input logic [31:0] e);
		return {e[23:18], e[15:10], e[7:2]};
	endfunction : six

	// Point 512 lives in the final-point register, not in the table.
	function automatic int pt(input int i, input int sh, input int c);
		if (i == 512)
			return int'(fin[c]);
		return int'({prec[2*i+1][sh+:10], prec[2*i][sh+8+:2],
			prec[2*i][sh+4+:4]});
	endfunction : pt

	function automatic logic [35:0] expect_pix(input logic eg, input logic ei,
			input logic [1:0] em, input logic [35:0] ed);
		logic [35:0] r;
		logic [11:0] v;
		int          p0, p1, y, sh;
		if (!eg && !ei)
			return ed;
		for (int c = 0; c < 3; c++) begin
			v = ed[35-12*c-:12];
			sh = 20 - 10 * c;
			if (ei)
				y = {leg[ed[7:0]][16-8*c+:8], 4'h0};
			else if (em == 2'h1)
				y = {prec[v[11:2]][sh+:10], 2'h0};
			else if (em == 2'h2) begin
				p0 = pt(v[11:3], sh, c);
				p1 = pt(v[11:3] + 1, sh, c);
				if (p1 < p0)
					p1 = p0;
				y = (p0 * 8 + (p1 - p0) * v[2:0]) >> 7;
				if (y > 4095)
					y = 4095;
			end else
				y = {leg[v[11:4]][16-8*c+:8], 4'h0};
			r[35-12*c-:12] = y[11:0];
		end
		return r;
	endfunction : expect_pix

	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic cmd(input logic w, input logic [19:0] a,
			input logic [31:0] wd);
		int k;
		@(posedge core_clk_i);
		cmd_valid_i <= 1'b1;
		{cmd_write_i, cmd_addr_i, cmd_wdata_i} <= {w, a, wd};
		k = 0;
		do begin
			@(posedge core_clk_i);
			k++;
		end while (cmd_ready_o !== 1'b1 && k < 50);
		if (cmd_ready_o !== 1'b1) begin
			n_fail++;
			$display("BAD %0t: command not taken", $time);
		end
		cmd_valid_i <= 1'b0;
	endtask : cmd

	task automatic rd(input logic [19:0] a, input logic [31:0] e);
		q_rsp.push_back(e);
		cmd(1'b0, a, 32'h0);
	endtask : rd

	task automatic vga(input logic w, input logic [7:0] i, input logic [17:0] wd,
			input logic [17:0] e);
		@(posedge core_clk_i);
		{vga_index_i, vga_wdata_i} <= {i, wd};
		if (w) begin
			vga_we_i <= 1'b1;
			@(posedge core_clk_i);
			vga_we_i <= 1'b0;
		end
		vga_re_i <= 1'b1;
		q_vga.push_back(e);
		@(posedge core_clk_i);
		vga_re_i <= 1'b0;
	endtask : vga

	task automatic results();
		if (q_pix.size() + q_rsp.size() + q_vga.size() != 0) begin
			n_fail++;
			$display("BAD %0t: answers missing", $time);
		end
		if (n_fail == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : results

	// ------------------------------------------------------------------
	// Clock, scoreboard and sequence
	// ------------------------------------------------------------------
	initial begin
		core_clk_i = 1'b0;
		forever #25 core_clk_i = ~core_clk_i;
	end

	always @(posedge core_clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			results();
		end
		if (out_valid_o === 1'b1) begin
			if (q_pix.size() == 0) chk(36'h1, 36'h0);
			else chk(out_data_o, q_pix.pop_front());
		end
		if (rsp_valid_o === 1'b1) begin
			if (q_rsp.size() == 0) chk(36'h1, 36'h0);
			else chk({4'h0, rsp_data_o}, {4'h0, q_rsp.pop_front()});
		end
		if (vga_rsp_valid_o === 1'b1) begin
			if (q_vga.size() == 0) chk(36'h1, 36'h0);
			else chk({18'h0, vga_rsp_data_o},
				{18'h0, q_vga.pop_front()});
		end
	end

	initial begin
		{resetn_i, cmd_valid_i, cmd_write_i, vga_we_i, vga_re_i} = '0;
		{pix_valid_i, pix_gamma_en_i, pix_indexed_i, pix_data_i} = '0;
		{cmd_addr_i, cmd_wdata_i, vga_index_i, vga_wdata_i} = '0;
		{disp_clk_on_i, pal_mode_i} = 3'h6;
		{n_fail, samples_checked, cycles} = '0;
		void'($urandom(93242));
		repeat (8) @(posedge core_clk_i);
		resetn_i <= 1'b1;
		for (int c = 0; c < 3; c++)
			rd(`DPG_MAX_BASE_A + 20'(4 * c), {15'h0, `DPG_MAX_RESET});
		for (int i = 0; i < 1024; i++) begin
			d = $urandom;
			if (i < 256) cmd(1'b1, `DPG_LEG_BASE_A + 20'(4 * i), d);
			if (i < 256) leg[i] = d & `DPG_LEG_MASK;
			cmd(1'b1, `DPG_PREC_BASE_A + 20'(4 * i), d);
			prec[i] = d & (i[0] ? `DPG_P10_MASK : `DPG_EVEN_MASK);
		end
		for (int c = 0; c < 3; c++) begin
			d = $urandom;
			cmd(1'b1, `DPG_MAX_BASE_A + 20'(4 * c), d);
			fin[c] = d[16:0];
			rd(`DPG_MAX_BASE_A + 20'(4 * c), {15'h0, fin[c]});
		end
		// Even dwords keep only their fields while the pipe is in mode 10b.
		for (int i = 0; i < 8; i++) begin
			pal_mode_i <= i < 4 ? 2'h2 : 2'h1;
			d = $urandom;
			cmd(1'b1, `DPG_LEG_BASE_A + 20'(4 * i), d);
			leg[i] = d & `DPG_LEG_MASK;
			rd(`DPG_LEG_BASE_A + 20'(4 * i), leg[i]);
			cmd(1'b1, `DPG_PREC_BASE_A + 20'(4 * i), d);
			prec[i] = d & (i[0] || i >= 4 ? `DPG_P10_MASK : `DPG_EVEN_MASK);
			rd(`DPG_PREC_BASE_A + 20'(4 * i), prec[i]);
		end
		disp_clk_on_i <= 1'b0;
		@(posedge core_clk_i);
		{vga_we_i, vga_index_i, vga_wdata_i} <= {1'b1, 8'h05, ~six(leg[5])};
		@(posedge core_clk_i);
		vga_we_i <= 1'b0;
		chk({35'h0, cmd_ready_o}, 36'h0);
		disp_clk_on_i <= 1'b1;
		vga(1'b0, 8'h05, 18'h0, six(leg[5]));
		for (int k = 0; k < 6; k++) begin
			{vi, vd} = 26'($urandom);
			vga(1'b1, vi, vd, vd);
			leg[vi] = {8'h0, vd[17:12], 2'h0, vd[11:6], 2'h0, vd[5:0], 2'h0};
			rd(`DPG_LEG_BASE_A + {10'h0, vi, 2'h0}, leg[vi]);
		end
		for (int n = 0; n < 800; n++) begin
			@(posedge core_clk_i);
			pd = {4'($urandom), $urandom};
			if (n % 8 == 0) pd = pd | 36'hFF8FF8FF8;
			{g, ix, m} = 4'($urandom);
			{pix_valid_i, pix_gamma_en_i, pix_indexed_i} <= {1'b1, g, ix};
			{pix_data_i, pal_mode_i} <= {pd, m};
			q_pix.push_back(expect_pix(g, ix, m, pd));
		end
		@(posedge core_clk_i);
		pix_valid_i <= 1'b0;
		repeat (10) @(posedge core_clk_i);
		results();
	end
endmodule : display_palette_gamma_lut_test
